// ==== design/fts_partner.sv ====
// controller unit and conflict monitor end, with an AHB-Lite register slave
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "fts_consts.svh"
module fts_partner #(
    parameter int unsigned START_DELAY_CYC = `FTS_START_DELAY_CYC,
    parameter int unsigned RELAY_DELAY_CYC = `FTS_RELAY_DELAY_CYC,
    parameter int unsigned INIT_CYC = 250,
    parameter int unsigned PHASE_CYC = 100,
    parameter int unsigned NPH = 8
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic inside_flash_switch,
    input wire logic outside_flash_switch,
    input wire logic conflict_fault,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic three_colour_ff,
    output logic irq_ff,
    fts_link_if.ctl_end link
);
    localparam int PW = $clog2(RELAY_DELAY_CYC + 1);
    localparam int TW = $clog2(PHASE_CYC + INIT_CYC + 1);
    localparam int NW = (NPH > 1) ? $clog2(NPH) : 1;

    generate
        if (START_DELAY_CYC < 1 || RELAY_DELAY_CYC < START_DELAY_CYC || PHASE_CYC < 1
            || NPH < 2 || NPH > 16) begin : g_bad_param
            $error("fts_partner parameters out of range");
        end
    endgenerate

    // pins are asynchronous: two flops before any use
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end else begin
            sync1_ff <= {conflict_fault, outside_flash_switch, inside_flash_switch};
            sync2_ff <= sync1_ff;
        end
    end
    logic inside_s, outside_s, fault_s;
    assign inside_s = sync2_ff[0];
    assign outside_s = sync2_ff[1];
    assign fault_s = sync2_ff[2];

    // state
    logic [PW-1:0] pwr_cnt_ff, nxt_pwr_cnt;
    logic sysrst_b_ff, nxt_sysrst_b;
    logic fault_ff, nxt_fault;
    logic relay_ff, nxt_relay;
    logic mon_stop_ff, nxt_mon_stop;
    logic inhibit_b_ff, nxt_inhibit_b;
    logic nxt_three_colour;
    logic [TW-1:0] tmr_ff, nxt_tmr;
    logic [NW-1:0] phase_ff, nxt_phase;
    logic init_done_ff, nxt_init_done;
    logic fop_ff, nxt_fop;
    logic latch_ff, nxt_latch;
    logic [NPH-1:0] calls_ff, nxt_calls;
    logic [`FTS_IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
    logic [`FTS_IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;
    logic nxt_irq;
    logic wr_pend_ff, nxt_wr_pend;
    logic [7:0] wr_addr_ff, nxt_wr_addr;
    logic [31:0] rdata_ff, nxt_rdata;

    function automatic logic [31:0] status_word(input logic [NW-1:0] ph);
        logic [31:0] w;
        w = 32'h00000000;
        w[`FTS_ST_THREE_COLOUR] = three_colour_ff;
        w[`FTS_ST_RELAY] = relay_ff;
        w[`FTS_ST_FAULT] = fault_ff;
        w[`FTS_ST_RECALL] = link.min_recall_request;
        w[`FTS_ST_STOP] = link.all_red_stop | mon_stop_ff;
        w[`FTS_ST_FOP] = fop_ff;
        w[`FTS_ST_FPE] = link.field_power_enable;
        w[`FTS_ST_PHASE_LSB +: NW] = ph;
        return w;
    endfunction

    logic powered, delay_done, ap_take, mreset, ctl_stop, ctl_run, step;
    logic [NW-1:0] ph_next;

    always_comb begin
        powered = !inside_s;
        ap_take = hsel && htrans[1] && hready;
        mreset = wr_pend_ff && (wr_addr_ff == `FTS_REG_CTRL) && hwdata[`FTS_CTRL_MRESET];
        // monitor: power-up delays, inside switch removes power
        nxt_pwr_cnt = pwr_cnt_ff;
        if (!powered) begin
            nxt_pwr_cnt = '0;
        end else if (pwr_cnt_ff < PW'(RELAY_DELAY_CYC)) begin
            nxt_pwr_cnt = pwr_cnt_ff + PW'(1);
        end
        delay_done = pwr_cnt_ff >= PW'(RELAY_DELAY_CYC);
        nxt_sysrst_b = powered && (pwr_cnt_ff >= PW'(START_DELAY_CYC));
        nxt_fault = powered && (fault_s || (fault_ff && latch_ff && !mreset));
        nxt_relay = powered && delay_done && !nxt_fault;
        nxt_mon_stop = !nxt_relay;
        nxt_inhibit_b = !(inside_s || outside_s);
        nxt_three_colour = relay_ff && !outside_s && link.field_power_enable;
        // controller unit
        ctl_stop = link.all_red_stop || mon_stop_ff;
        ctl_run = sysrst_b_ff && !ctl_stop;
        ph_next = (phase_ff == NW'(NPH - 1)) ? '0 : phase_ff + NW'(1);
        nxt_tmr = tmr_ff;
        nxt_phase = phase_ff;
        nxt_init_done = init_done_ff;
        nxt_fop = fop_ff;
        step = 1'b0;
        if (!sysrst_b_ff) begin
            nxt_tmr = TW'(INIT_CYC);
            nxt_phase = '0;
            nxt_init_done = 1'b0;
            nxt_fop = 1'b0;
        end else if (mon_stop_ff) begin
            // restart after a monitor stop must earn a fresh full-op
            nxt_fop = 1'b0;
        end else if (ctl_run) begin
            // uncalled phases are skipped unless recall forces service
            step = (tmr_ff == '0) ||
                (init_done_ff && !link.min_recall_request && !calls_ff[phase_ff]);
            if (step) begin
                nxt_tmr = TW'(PHASE_CYC - 1);
                if (!init_done_ff) begin
                    nxt_init_done = 1'b1;
                end else begin
                    nxt_phase = ph_next;
                    if (ph_next == '0) begin
                        nxt_fop = 1'b1;
                    end
                end
            end else begin
                nxt_tmr = tmr_ff - TW'(1);
            end
        end
        // registers
        nxt_latch = latch_ff;
        nxt_calls = calls_ff;
        nxt_irq_mask = irq_mask_ff;
        nxt_irq_stat = irq_stat_ff;
        if (wr_pend_ff) begin
            unique case (wr_addr_ff)
                `FTS_REG_CTRL: nxt_latch = hwdata[`FTS_CTRL_LATCH];
                `FTS_REG_CALLS: nxt_calls = hwdata[NPH-1:0];
                `FTS_REG_IRQ_STAT: nxt_irq_stat = irq_stat_ff & ~hwdata[`FTS_IRQ_W-1:0];
                `FTS_REG_IRQ_MASK: nxt_irq_mask = hwdata[`FTS_IRQ_W-1:0];
                default: nxt_latch = latch_ff;
            endcase
        end
        // events after the clear so that a coincident set wins
        if (nxt_fault && !fault_ff) begin
            nxt_irq_stat[`FTS_IRQ_FAULT] = 1'b1;
        end
        if (nxt_three_colour && !three_colour_ff) begin
            nxt_irq_stat[`FTS_IRQ_COLOUR_ON] = 1'b1;
        end
        if (!nxt_three_colour && three_colour_ff) begin
            nxt_irq_stat[`FTS_IRQ_FLASH_ON] = 1'b1;
        end
        nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
        nxt_wr_pend = ap_take && hwrite;
        nxt_wr_addr = haddr[7:0];
        nxt_rdata = 32'h00000000;
        if (ap_take && !hwrite) begin
            unique case (haddr[7:0])
                `FTS_REG_CTRL: nxt_rdata[`FTS_CTRL_LATCH] = latch_ff;
                `FTS_REG_CALLS: nxt_rdata[NPH-1:0] = calls_ff;
                `FTS_REG_STATUS: nxt_rdata = status_word(phase_ff);
                `FTS_REG_IRQ_STAT: nxt_rdata[`FTS_IRQ_W-1:0] = irq_stat_ff;
                `FTS_REG_IRQ_MASK: nxt_rdata[`FTS_IRQ_W-1:0] = irq_mask_ff;
                default: nxt_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pwr_cnt_ff <= '0;
            sysrst_b_ff <= 1'b0;
            fault_ff <= 1'b0;
            relay_ff <= 1'b0;
            mon_stop_ff <= 1'b1;
            inhibit_b_ff <= 1'b1;
            three_colour_ff <= 1'b0;
            tmr_ff <= '0;
            phase_ff <= '0;
            init_done_ff <= 1'b0;
            fop_ff <= 1'b0;
            latch_ff <= 1'b0;
            calls_ff <= NPH'(`FTS_CALLS_RESET);
            irq_stat_ff <= '0;
            irq_mask_ff <= `FTS_MASK_RESET;
            irq_ff <= 1'b0;
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rdata_ff <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            pwr_cnt_ff <= nxt_pwr_cnt;
            sysrst_b_ff <= nxt_sysrst_b;
            fault_ff <= nxt_fault;
            relay_ff <= nxt_relay;
            mon_stop_ff <= nxt_mon_stop;
            inhibit_b_ff <= nxt_inhibit_b;
            three_colour_ff <= nxt_three_colour;
            tmr_ff <= nxt_tmr;
            phase_ff <= nxt_phase;
            init_done_ff <= nxt_init_done;
            fop_ff <= nxt_fop;
            latch_ff <= nxt_latch;
            calls_ff <= nxt_calls;
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            irq_ff <= nxt_irq;
            wr_pend_ff <= nxt_wr_pend;
            wr_addr_ff <= nxt_wr_addr;
            rdata_ff <= nxt_rdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    assign hrdata = rdata_ff;
    assign link.full_operating_point = fop_ff;
    assign link.fault_stop_time = mon_stop_ff;
    assign link.sys_reset_b = sysrst_b_ff;
    assign link.flash_in_inhibit_b = inhibit_b_ff;
endmodule // fts_partner

// ==== design/fts_consts.svh ====
// constants for the flash transfer sequencer and its partner end
// Behaviour
// - Init: recall on, field power off until full-op
// - Full-op with hold enabled: stop-time exactly 3 s
// - Full-op: recall off, field power on together
// - Fault stop: power stays on, no recall, armed
// - Armed stop removed: power off, back to init
// - After fault reset: recall again, await full-op
// - Flash-in inhibit low: reset, power off, recall on
// - Three-colour needs relay path and field power enable
// - Recall serves all phases; otherwise demand service
// - Fault stop-time freezes controller in current interval
// - Monitor fault drops relays, asserts stop-time
// - Non-latching clears itself; latched needs manual reset
// - Monitor reset re-energizes relays immediately
// - System reset held 2.5 s after power-up
// - Stop-time held 5 s after power-up
`ifndef FTS_CONSTS_SVH
`define FTS_CONSTS_SVH

`define FTS_CLK_HZ 25000000
`define FTS_ALL_RED_S 3
`define FTS_START_DELAY_MS 2500
`define FTS_RELAY_DELAY_MS 5000
`define FTS_ALL_RED_CYC (`FTS_ALL_RED_S * `FTS_CLK_HZ)
`define FTS_START_DELAY_CYC (`FTS_START_DELAY_MS * (`FTS_CLK_HZ / 1000))
`define FTS_RELAY_DELAY_CYC (`FTS_RELAY_DELAY_MS * (`FTS_CLK_HZ / 1000))

`define FTS_REG_CTRL 8'h00
`define FTS_REG_CALLS 8'h04
`define FTS_REG_STATUS 8'h08
`define FTS_REG_IRQ_STAT 8'h0C
`define FTS_REG_IRQ_MASK 8'h10

`define FTS_CTRL_LATCH 0
`define FTS_CTRL_MRESET 1

`define FTS_ST_THREE_COLOUR 0
`define FTS_ST_RELAY 1
`define FTS_ST_FAULT 2
`define FTS_ST_RECALL 3
`define FTS_ST_STOP 4
`define FTS_ST_FOP 5
`define FTS_ST_FPE 6
`define FTS_ST_PHASE_LSB 8

`define FTS_IRQ_FAULT 0
`define FTS_IRQ_COLOUR_ON 1
`define FTS_IRQ_FLASH_ON 2
`define FTS_IRQ_W 3

`define FTS_CALLS_RESET 32'h00000000
`define FTS_MASK_RESET 3'h0

`endif

// ==== design/fts_pkg.sv ====
// types used by the sequencer end of the flash transfer link
package fts_pkg;
    typedef enum logic [1:0] {
        FTS_INIT = 2'b00,
        FTS_HOLD = 2'b01,
        FTS_RUN = 2'b10,
        FTS_FAULT = 2'b11
    } fts_seq_state_e;
endpackage

// ==== design/fts_link_if.sv ====
// link between the sequencer and the controller unit / conflict monitor
`timescale 1ns/1ps
interface fts_link_if;
    logic min_recall_request;
    logic field_power_enable;
    logic all_red_stop;
    logic full_operating_point;
    logic fault_stop_time;
    logic sys_reset_b;
    logic flash_in_inhibit_b;

    modport seq_end (
        output min_recall_request,
        output field_power_enable,
        output all_red_stop,
        input full_operating_point,
        input fault_stop_time,
        input sys_reset_b,
        input flash_in_inhibit_b
    );

    modport ctl_end (
        input min_recall_request,
        input field_power_enable,
        input all_red_stop,
        output full_operating_point,
        output fault_stop_time,
        output sys_reset_b,
        output flash_in_inhibit_b
    );
endinterface // fts_link_if

// ==== design/fts_sequencer.sv ====
// flash transfer sequencer: device end of the link
`timescale 1ns/1ps
`include "fts_consts.svh"
module fts_sequencer #(
    parameter int unsigned ALL_RED_CYC = `FTS_ALL_RED_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic all_red_hold_enable,
    output fts_pkg::fts_seq_state_e state_ff,
    fts_link_if.seq_end link
);
    localparam int CW = $clog2(ALL_RED_CYC + 1);

    generate
        if (ALL_RED_CYC < 1) begin : g_bad_cyc
            $error("ALL_RED_CYC must be at least one");
        end
    endgenerate

    fts_pkg::fts_seq_state_e nxt_state;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic recall_ff;
    logic nxt_recall;
    logic fpe_ff;
    logic nxt_fpe;
    logic stop_ff;
    logic nxt_stop;
    logic go_init;

    // both the monitor's system reset and the inhibit pull back to init
    assign go_init = !link.sys_reset_b || !link.flash_in_inhibit_b;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_recall = recall_ff;
        nxt_fpe = fpe_ff;
        nxt_stop = stop_ff;
        if (go_init) begin
            nxt_state = fts_pkg::FTS_INIT;
            nxt_recall = 1'b1;
            nxt_fpe = 1'b0;
            nxt_stop = 1'b0;
            nxt_cnt = '0;
        end else begin
            unique case (state_ff)
                fts_pkg::FTS_INIT: begin
                    nxt_recall = 1'b1;
                    nxt_fpe = 1'b0;
                    // full-op is not taken while the monitor holds stop-time
                    if (link.full_operating_point && !link.fault_stop_time) begin
                        nxt_recall = 1'b0;
                        nxt_fpe = 1'b1;
                        if (all_red_hold_enable) begin
                            nxt_state = fts_pkg::FTS_HOLD;
                            nxt_stop = 1'b1;
                            nxt_cnt = CW'(ALL_RED_CYC - 1);
                        end else begin
                            nxt_state = fts_pkg::FTS_RUN;
                        end
                    end
                end
                fts_pkg::FTS_HOLD: begin
                    if (link.fault_stop_time) begin
                        nxt_state = fts_pkg::FTS_FAULT;
                        nxt_stop = 1'b0;
                    end else if (cnt_ff == '0) begin
                        nxt_state = fts_pkg::FTS_RUN;
                        nxt_stop = 1'b0;
                    end else begin
                        nxt_cnt = cnt_ff - CW'(1);
                    end
                end
                fts_pkg::FTS_RUN: begin
                    if (link.fault_stop_time) begin
                        nxt_state = fts_pkg::FTS_FAULT;
                    end
                end
                fts_pkg::FTS_FAULT: begin
                    nxt_fpe = 1'b1;
                    nxt_recall = 1'b0;
                    if (!link.fault_stop_time) begin
                        nxt_state = fts_pkg::FTS_INIT;
                        nxt_fpe = 1'b0;
                        nxt_recall = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_ff <= fts_pkg::FTS_INIT;
            cnt_ff <= '0;
            recall_ff <= 1'b1;
            fpe_ff <= 1'b0;
            stop_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            recall_ff <= nxt_recall;
            fpe_ff <= nxt_fpe;
            stop_ff <= nxt_stop;
        end
    end

    assign link.min_recall_request = recall_ff;
    assign link.field_power_enable = fpe_ff;
    assign link.all_red_stop = stop_ff;
endmodule // fts_sequencer

// ==== testbench/fts_link_sva.sv ====
// link checker for the flash transfer sequencer
`timescale 1ns/1ps
module fts_link_sva #(
    parameter int unsigned ALL_RED_CYC = 20
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic all_red_hold_enable,
    input wire logic min_recall_request,
    input wire logic field_power_enable,
    input wire logic all_red_stop,
    input wire logic full_operating_point,
    input wire logic fault_stop_time,
    input wire logic sys_reset_b,
    input wire logic flash_in_inhibit_b
);
    logic [31:0] hold_cnt_ff;
    logic [31:0] nxt_hold_cnt;

    // counts edges with the all-red stop seen high
    always_comb begin
        nxt_hold_cnt = all_red_stop ? hold_cnt_ff + 32'h1 : 32'h0;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b)
            hold_cnt_ff <= 32'h0;
        else
            hold_cnt_ff <= nxt_hold_cnt;
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    sequence s_fop_seen;
        min_recall_request && full_operating_point && !fault_stop_time &&
            flash_in_inhibit_b && sys_reset_b;
    endsequence
    // two cycles of fault with power on guarantees the armed state
    sequence s_armed;
        field_power_enable && fault_stop_time ##1 field_power_enable && fault_stop_time;
    endsequence
    sequence s_released;
        s_armed ##1 !fault_stop_time;
    endsequence

    chk_recall_power_excl: assert property (min_recall_request != field_power_enable)
        else $error("recall and field power not complementary");
    chk_init_stays: assert property (min_recall_request && !full_operating_point |=>
        min_recall_request) else $error("left init without full-op");
    chk_fop_transfer: assert property (s_fop_seen |=>
        !min_recall_request && field_power_enable) else $error("full-op not taken");
    chk_hold_cause: assert property ($rose(field_power_enable) |->
        all_red_stop == $past(all_red_hold_enable)) else $error("all-red stop wrong at start");
    chk_hold_bound: assert property (all_red_stop |-> hold_cnt_ff < ALL_RED_CYC)
        else $error("all-red stop too long");
    chk_hold_length: assert property ($fell(all_red_stop) && !$past(fault_stop_time) &&
        $past(flash_in_inhibit_b) && $past(sys_reset_b) |-> hold_cnt_ff == ALL_RED_CYC)
        else $error("all-red stop too short");
    chk_fault_keeps: assert property (field_power_enable && fault_stop_time &&
        flash_in_inhibit_b && sys_reset_b |=> field_power_enable && !min_recall_request &&
        !all_red_stop) else $error("fault stop dropped power or raised recall");
    chk_fault_release: assert property (s_released |=>
        !field_power_enable && min_recall_request) else $error("no reset after fault stop");
    chk_power_needs_fop: assert property ($rose(field_power_enable) |->
        $past(full_operating_point) && $past(min_recall_request)) else $error("power without full-op");
    chk_inhibit_reset: assert property (!flash_in_inhibit_b || !sys_reset_b |=>
        !field_power_enable && min_recall_request && !all_red_stop)
        else $error("inhibit did not reset");
endmodule // fts_link_sva

// ==== testbench/tb_top.sv ====
// testbench joining the sequencer and the controller end over the link
`timescale 1ns/1ps
`include "fts_consts.svh"
module tb_top;
    localparam int unsigned ARC = 20;
    logic mclk, rst_b, all_red_hold_enable, inside_sw, outside_sw, fault_pin;
    logic hsel, hwrite, hreadyout, hresp, three_colour_ff, irq_ff;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    fts_pkg::fts_seq_state_e seq_state;
    int bad_count, n_compared, n;
    logic [2:0] ph;

    fts_link_if link();
    fts_sequencer #(.ALL_RED_CYC(ARC)) u_fts_sequencer (.mclk(mclk), .rst_b(rst_b),
        .all_red_hold_enable(all_red_hold_enable), .state_ff(seq_state), .link(link));
    fts_partner #(.START_DELAY_CYC(30), .RELAY_DELAY_CYC(60), .INIT_CYC(5), .PHASE_CYC(4),
        .NPH(8)) u_fts_partner (.mclk(mclk), .rst_b(rst_b), .inside_flash_switch(inside_sw),
        .outside_flash_switch(outside_sw), .conflict_fault(fault_pin), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .three_colour_ff(three_colour_ff), .irq_ff(irq_ff), .link(link));
    fts_link_sva #(.ALL_RED_CYC(ARC)) u_fts_link_sva (.mclk(mclk), .rst_b(rst_b),
        .all_red_hold_enable(all_red_hold_enable), .min_recall_request(link.min_recall_request),
        .field_power_enable(link.field_power_enable), .all_red_stop(link.all_red_stop),
        .full_operating_point(link.full_operating_point), .fault_stop_time(link.fault_stop_time),
        .sys_reset_b(link.sys_reset_b), .flash_in_inhibit_b(link.flash_in_inhibit_b));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // 0 power, 1 recall, 2 fault stop, 3 sys reset, 4 colour, 5 inhibit, 6 irq
    function logic pick(input int w);
        case (w)
            0: pick = link.field_power_enable;
            1: pick = link.min_recall_request;
            2: pick = link.fault_stop_time;
            3: pick = link.sys_reset_b;
            4: pick = three_colour_ff;
            5: pick = link.flash_in_inhibit_b;
            default: pick = irq_ff;
        endcase
    endfunction

    task wrap_up;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask

    // bounded wait for one link or port level
    task wait_on(input int w, input logic v, input int lim);
        int k;
        k = 0;
        while (pick(w) !== v && k < lim) begin
            @(posedge mclk);
            k++;
        end
        check($sformatf("wait %0d", w), {31'h0, v}, {31'h0, pick(w)});
        if (k >= lim && pick(w) !== v)
            wrap_up();
    endtask

    // single word transfer; holds each phase until hready seen high
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'b10;
        k = 0;
        @(posedge mclk);
        while (hreadyout !== 1'b1 && k < 50) begin
            @(posedge mclk);
            k++;
        end
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge mclk);
        while (hreadyout !== 1'b1 && k < 50) begin
            @(posedge mclk);
            k++;
        end
        rd = hrdata;
        check("bus answer", 32'h1, {31'h0, hreadyout});
        check("bus response", 32'h0, {31'h0, hresp});
        if (k >= 50)
            wrap_up();
    endtask

    task rdchk(input string name, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(name, exp, rd & m);
    endtask

    initial begin
        rst_b = 1'b0;
        all_red_hold_enable = 1'b1;
        inside_sw = 1'b0;
        outside_sw = 1'b0;
        fault_pin = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        bad_count = 0;
        n_compared = 0;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        check("recall at init", 32'h1, {31'h0, pick(1)});
        check("power at init", 32'h0, {31'h0, pick(0)});
        rdchk("calls reset", `FTS_REG_CALLS, 32'hFFFFFFFF, `FTS_CALLS_RESET);
        rdchk("mask reset", `FTS_REG_IRQ_MASK, 32'h7, 32'h0);
        ahb(1'b1, `FTS_REG_CALLS, 32'h55);
        rdchk("calls", `FTS_REG_CALLS, 32'hFF, 32'h55);
        rdchk("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
        ahb(1'b1, `FTS_REG_IRQ_MASK, 32'h2);
        wait_on(2, 1'b0, 300);
        wait_on(0, 1'b1, 600);
        check("recall off", 32'h0, {31'h0, pick(1)});
        check("all-red on", 32'h1, {31'h0, link.all_red_stop});
        check("state hold", {30'h0, fts_pkg::FTS_HOLD}, {30'h0, seq_state});
        rdchk("controller stop", `FTS_REG_STATUS, 32'h10, 32'h10);
        n = 2;
        while (link.all_red_stop === 1'b1 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        check("all-red cycles", ARC, n);
        rdchk("stop gone", `FTS_REG_STATUS, 32'h10, 32'h0);
        wait_on(4, 1'b1, 10);
        rdchk("colour flag", `FTS_REG_IRQ_STAT, 32'h2, 32'h2);
        wait_on(6, 1'b1, 5);
        ahb(1'b1, `FTS_REG_IRQ_STAT, 32'h2);
        wait_on(6, 1'b0, 5);
        // non-latching fault
        fault_pin <= 1'b1;
        wait_on(2, 1'b1, 20);
        repeat (3) @(posedge mclk);
        check("power in fault", 32'h1, {31'h0, pick(0)});
        check("recall in fault", 32'h0, {31'h0, pick(1)});
        check("state fault", {30'h0, fts_pkg::FTS_FAULT}, {30'h0, seq_state});
        check("colour in fault", 32'h0, {31'h0, pick(4)});
        rdchk("fault flag", `FTS_REG_IRQ_STAT, 32'h1, 32'h1);
        rdchk("flash flag", `FTS_REG_IRQ_STAT, 32'h4, 32'h4);
        check("masked irq", 32'h0, {31'h0, pick(6)});
        ahb(1'b1, `FTS_REG_IRQ_MASK, 32'h1);
        wait_on(6, 1'b1, 5);
        fault_pin <= 1'b0;
        wait_on(2, 1'b0, 20);
        wait_on(1, 1'b1, 3);
        check("power after fault", 32'h0, {31'h0, pick(0)});
        ahb(1'b1, `FTS_REG_IRQ_STAT, 32'h7);
        wait_on(6, 1'b0, 5);
        wait_on(0, 1'b1, 600);
        // latched fault needs the manual reset
        ahb(1'b1, `FTS_REG_CTRL, 32'h1);
        fault_pin <= 1'b1;
        wait_on(2, 1'b1, 20);
        fault_pin <= 1'b0;
        ahb(1'b0, `FTS_REG_STATUS, 32'h0);
        ph = rd[10:8];
        repeat (16) @(posedge mclk);
        rdchk("frozen phase", `FTS_REG_STATUS, 32'h700, {21'h0, ph, 8'h00});
        check("latched stop", 32'h1, {31'h0, pick(2)});
        ahb(1'b1, `FTS_REG_CTRL, 32'h3);
        wait_on(2, 1'b0, 10);
        wait_on(1, 1'b1, 3);
        wait_on(0, 1'b1, 600);
        // outside switch, hold disabled
        all_red_hold_enable <= 1'b0;
        outside_sw <= 1'b1;
        wait_on(5, 1'b0, 10);
        wait_on(0, 1'b0, 3);
        check("recall on inhibit", 32'h1, {31'h0, pick(1)});
        wait_on(4, 1'b0, 5);
        outside_sw <= 1'b0;
        wait_on(5, 1'b1, 10);
        check("colour before enable", 32'h0, {31'h0, pick(4)});
        wait_on(0, 1'b1, 600);
        check("no all-red", 32'h0, {31'h0, link.all_red_stop});
        wait_on(4, 1'b1, 5);
        // inside switch removes power
        inside_sw <= 1'b1;
        wait_on(3, 1'b0, 10);
        wait_on(1, 1'b1, 3);
        inside_sw <= 1'b0;
        wait_on(3, 1'b1, 200);
        check("stop at start", 32'h1, {31'h0, pick(2)});
        wait_on(2, 1'b0, 200);
        wait_on(0, 1'b1, 600);
        wrap_up();
    end
endmodule // tb_top
